// ### umapd_defs.svh
`ifndef UMAPD_DEFS_SVH
`define UMAPD_DEFS_SVH
// =====================================================================
// element word layout
`define UMAPD_SID_MSB 31
`define UMAPD_SID_LSB 18
`define UMAPD_IUC_MSB 17
`define UMAPD_IUC_LSB 14
`define UMAPD_OFS_MSB 13
`define UMAPD_OFS_LSB 0
// =====================================================================
// usage codes
`define UMAPD_IUC_REQ 4'h1
`define UMAPD_IUC_REQDATA 4'h2
`define UMAPD_IUC_INIT_MAINT 4'h3
`define UMAPD_IUC_STN_MAINT 4'h4
`define UMAPD_IUC_SHORT 4'h5
`define UMAPD_IUC_LONG 4'h6
`define UMAPD_IUC_NULL 4'h7
`define UMAPD_IUC_DACK 4'h8
`define UMAPD_IUC_EXP 4'hF
// =====================================================================
// special sids and field defaults
`define UMAPD_SID_BCAST 14'h3FFF
`define UMAPD_SID_MCAST_LO 14'h3E00
`define UMAPD_SID_ZERO 14'h0000
`define UMAPD_BACKOFF_MASK 8'h0F
`define UMAPD_M_DEFAULT 4
`endif

// ### umapd_pkg.sv
package umapd_pkg;
    // =================================================================
    // burst profile selected for the transmitter
    typedef enum logic [3:0] {
        UMAPD_PROF_NONE = 4'h0,
        UMAPD_PROF_REQ = 4'h1,
        UMAPD_PROF_REQDATA = 4'h2,
        UMAPD_PROF_INIT = 4'h3,
        UMAPD_PROF_STN = 4'h4,
        UMAPD_PROF_SHORT = 4'h5,
        UMAPD_PROF_LONG = 4'h6
    } umapd_prof_e;
    // map header as carried between the ends
    typedef struct packed {
        logic [7:0] chan_id;
        logic [7:0] ucd_count;
        logic [7:0] num_elem;
        logic [31:0] alloc_start;
        logic [31:0] ack_time;
        logic [7:0] rng_bo_start;
        logic [7:0] rng_bo_end;
        logic [7:0] data_bo_start;
        logic [7:0] data_bo_end;
    } umapd_hdr_s;
    typedef logic [31:0] umapd_word_t;
endpackage

// ### umapd_if.sv
`timescale 1ns/1ps
// map transfer: header with hdr_valid, then words with word_valid
interface umapd_if;
    import umapd_pkg::*;
    logic hdr_valid;
    umapd_hdr_s hdr;
    logic word_valid;
    umapd_word_t word;
    logic word_ready;
    modport headend (output hdr_valid, output hdr, output word_valid, output word, input word_ready);
    modport modem (input hdr_valid, input hdr, input word_valid, input word, output word_ready);
endinterface

// ### umapd_elem_dec.sv
`timescale 1ns/1ps
`include "umapd_defs.svh"
// splits an element word and classifies its usage code
module umapd_elem_dec
    import umapd_pkg::*;
(
    input wire umapd_word_t word,
    output logic [13:0] sid,
    output logic [3:0] iuc,
    output logic [13:0] ofs,
    output logic is_grant,
    output logic is_rsvd
);
    // =================================================================
    // field split and class
    always_comb begin
        sid = word[`UMAPD_SID_MSB:`UMAPD_SID_LSB];
        iuc = word[`UMAPD_IUC_MSB:`UMAPD_IUC_LSB];
        ofs = word[`UMAPD_OFS_MSB:`UMAPD_OFS_LSB];
        is_grant = (iuc >= `UMAPD_IUC_REQ) && (iuc <= `UMAPD_IUC_LONG);
        is_rsvd = (iuc > `UMAPD_IUC_DACK) && (iuc < `UMAPD_IUC_EXP);
    end
endmodule

// ### umapd_headend.sv
`timescale 1ns/1ps
`include "umapd_defs.svh"
// builds a map: header, then the element words given by the user
module umapd_headend
    import umapd_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire umapd_hdr_s HDR_IN,
    input wire logic ELEM_VALID,
    input wire umapd_word_t ELEM_IN,
    output logic ELEM_READY,
    output logic BUSY,
    umapd_if.headend lnk
);
    typedef enum logic [2:0] {
        UMAPD_H_IDLE = 3'b001,
        UMAPD_H_HDR = 3'b010,
        UMAPD_H_WORDS = 3'b100
    } umapd_hst_e;
    typedef struct packed {
        umapd_hst_e st;
        logic hdr_valid;
        umapd_hdr_s hdr;
        logic word_valid;
        umapd_word_t word;
        logic [7:0] left;
        logic [13:0] ext;
        logic busy;
    } umapd_hstate_s;
    umapd_hstate_s cur_ff, nxt_cur;
    logic [13:0] e_sid;
    logic [3:0] e_iuc;
    logic [13:0] e_ofs;
    umapd_elem_dec u_dec (
        .word(ELEM_IN),
        .sid(e_sid),
        .iuc(e_iuc),
        .ofs(e_ofs),
        .is_grant(),
        .is_rsvd()
    );
    // =================================================================
    // header and element sequencing
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.hdr_valid = 1'b0;
        if (lnk.word_ready) begin
            nxt_cur.word_valid = 1'b0;
        end
        case (cur_ff.st)
            UMAPD_H_IDLE: begin
                if (START) begin
                    nxt_cur.hdr = HDR_IN;
                    nxt_cur.hdr.rng_bo_start = HDR_IN.rng_bo_start & `UMAPD_BACKOFF_MASK;
                    nxt_cur.hdr.rng_bo_end = HDR_IN.rng_bo_end & `UMAPD_BACKOFF_MASK;
                    nxt_cur.hdr.data_bo_start = HDR_IN.data_bo_start & `UMAPD_BACKOFF_MASK;
                    nxt_cur.hdr.data_bo_end = HDR_IN.data_bo_end & `UMAPD_BACKOFF_MASK;
                    nxt_cur.left = HDR_IN.num_elem;
                    nxt_cur.ext = 14'h0000;
                    nxt_cur.st = UMAPD_H_HDR;
                end
            end
            UMAPD_H_HDR: begin
                nxt_cur.hdr_valid = 1'b1;
                nxt_cur.st = (cur_ff.left == 8'h00) ? UMAPD_H_IDLE : UMAPD_H_WORDS;
            end
            UMAPD_H_WORDS: begin
                if (ELEM_VALID && (!cur_ff.word_valid || lnk.word_ready)) begin
                    nxt_cur.word_valid = 1'b1;
                    nxt_cur.word = ELEM_IN;
                    if (cur_ff.ext != 14'h0000) begin
                        nxt_cur.ext = cur_ff.ext - 14'h0001;
                        if (cur_ff.ext == 14'h0001 && cur_ff.left == 8'h00) begin
                            nxt_cur.st = UMAPD_H_IDLE;
                        end
                    end else begin
                        nxt_cur.left = cur_ff.left - 8'h01;
                        if (e_iuc == `UMAPD_IUC_EXP) begin
                            nxt_cur.ext = e_ofs;
                        end
                        if (e_iuc == `UMAPD_IUC_DACK) begin
                            nxt_cur.word[`UMAPD_OFS_MSB:`UMAPD_OFS_LSB] = e_ofs;
                        end
                        if (cur_ff.left == 8'h01 && !(e_iuc == `UMAPD_IUC_EXP && e_ofs != 14'h0000)) begin
                            nxt_cur.st = UMAPD_H_IDLE;
                        end
                    end
                end
            end
            default: nxt_cur.st = UMAPD_H_IDLE;
        endcase
        // busy is registered so the output comes straight from a flop
        nxt_cur.busy = (nxt_cur.st != UMAPD_H_IDLE);
    end
    // =================================================================
    // state register
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cur_ff <= '{st: UMAPD_H_IDLE, hdr: '0, word: '0, left: 8'h00, ext: 14'h0000, default: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end
    // =================================================================
    // outputs
    assign lnk.hdr_valid = cur_ff.hdr_valid;
    assign lnk.hdr = cur_ff.hdr;
    assign lnk.word_valid = cur_ff.word_valid;
    assign lnk.word = cur_ff.word;
    assign ELEM_READY = (cur_ff.st == UMAPD_H_WORDS) && (!cur_ff.word_valid || lnk.word_ready);
    assign BUSY = cur_ff.busy;
endmodule

// ### umapd_modem.sv
`timescale 1ns/1ps
`include "umapd_defs.svh"
// Overview of operation
// - element word: sid 14, code 4, offset 14
// - code 1 starts request contention region
// - code 2 starts multicast request/data region
// - code 3 broadcast: initial ranging maintenance
// - code 4 unicast: periodic ranging maintenance
// - codes 5/6 grant; zero length is pending
// - code 7 null ends previous grant
// - data ack offset set to map length; the headend passes the element's own offset through unchanged
// - code 15 skips its extra words
// - ranging backoff exponents 0-15, upper zero
// - data backoff exponents 0-15, upper zero
// - keep lower 26-M bits of times
// - start time anchors element offsets
// - ack time drives collision decision
// - ucd count names the burst descriptor
// - element count bounds elements read
// - periodic ranging sid temporary or first
// - burst profile chosen by usage code
// - act only on own channel maps
// - short grant descriptor has burst size
module umapd_modem
    import umapd_pkg::*;
#(
    parameter int M_BITS = `UMAPD_M_DEFAULT
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] MY_CHAN,
    input wire logic [13:0] MY_SID,
    input wire logic [31:0] LAST_TX_TIME,
    umapd_if.modem lnk,
    output logic [7:0] UCD_COUNT,
    output logic [31:0] MAP_START,
    output logic [31:0] ACK_TIME,
    output logic [3:0] RNG_BO_START,
    output logic [3:0] RNG_BO_END,
    output logic [3:0] DATA_BO_START,
    output logic [3:0] DATA_BO_END,
    output logic COLLIDED,
    output logic IVAL_VALID,
    output logic [31:0] IVAL_START,
    output logic [13:0] IVAL_LEN,
    output logic [13:0] IVAL_SID,
    output logic IVAL_MINE,
    output logic IVAL_PENDING,
    output umapd_prof_e IVAL_PROF,
    output logic MAP_DONE
);
    localparam int TBITS = 26 - M_BITS;
    // refuse a time width the trim mask cannot serve
    if (M_BITS < 1 || M_BITS > 25) begin : g_bad_m
        $error("M_BITS out of range");
    end
    typedef enum logic [2:0] {
        UMAPD_M_IDLE = 3'b001,
        UMAPD_M_ELEM = 3'b010,
        UMAPD_M_SKIP = 3'b100
    } umapd_mst_e;
    typedef struct packed {
        umapd_mst_e st;
        logic [7:0] left;
        logic [13:0] skip;
        logic have_prev;
        logic [13:0] p_sid;
        logic [3:0] p_iuc;
        logic [13:0] p_ofs;
        logic [7:0] ucd;
        logic [31:0] start;
        logic [31:0] ack;
        logic [15:0] bo;
        logic coll;
        logic iv_valid;
        logic [31:0] iv_start;
        logic [13:0] iv_len;
        logic [13:0] iv_sid;
        logic iv_mine;
        logic iv_pend;
        umapd_prof_e iv_prof;
        logic done;
    } umapd_mstate_s;
    umapd_mstate_s cur_ff, nxt_cur;
    logic [13:0] e_sid;
    logic [3:0] e_iuc;
    logic [13:0] e_ofs;
    logic e_grant;
    logic e_rsvd;
    umapd_elem_dec u_dec (
        .word(lnk.word),
        .sid(e_sid),
        .iuc(e_iuc),
        .ofs(e_ofs),
        .is_grant(e_grant),
        .is_rsvd(e_rsvd)
    );
    // =================================================================
    // keep the lower 26-M bits of a header time
    function automatic logic [31:0] trim_time(input logic [31:0] t);
        logic [31:0] mask;
        mask = (32'h0000_0001 << TBITS) - 32'h0000_0001;
        return t & mask;
    endfunction
    // profile and addressing of a stored element
    function automatic umapd_prof_e prof_of(input logic [3:0] iuc, input logic [13:0] sid);
        umapd_prof_e p;
        p = UMAPD_PROF_NONE;
        case (iuc)
            `UMAPD_IUC_REQ: p = UMAPD_PROF_REQ;
            `UMAPD_IUC_REQDATA: p = (sid >= `UMAPD_SID_MCAST_LO) ? UMAPD_PROF_REQDATA : UMAPD_PROF_NONE;
            `UMAPD_IUC_INIT_MAINT: p = (sid == `UMAPD_SID_BCAST) ? UMAPD_PROF_INIT : UMAPD_PROF_NONE;
            `UMAPD_IUC_STN_MAINT: p = UMAPD_PROF_STN;
            `UMAPD_IUC_SHORT: p = UMAPD_PROF_SHORT;
            `UMAPD_IUC_LONG: p = UMAPD_PROF_LONG;
            default: p = UMAPD_PROF_NONE;
        endcase
        return p;
    endfunction
    // =================================================================
    // map parsing and interval emission
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.iv_valid = 1'b0;
        nxt_cur.done = 1'b0;
        case (cur_ff.st)
            UMAPD_M_IDLE: begin
                if (lnk.hdr_valid && lnk.hdr.chan_id == MY_CHAN) begin
                    nxt_cur.ucd = lnk.hdr.ucd_count;
                    nxt_cur.start = trim_time(lnk.hdr.alloc_start);
                    nxt_cur.ack = trim_time(lnk.hdr.ack_time);
                    nxt_cur.coll = (trim_time(LAST_TX_TIME) <= trim_time(lnk.hdr.ack_time));
                    nxt_cur.bo = {lnk.hdr.rng_bo_start[3:0], lnk.hdr.rng_bo_end[3:0],
                        lnk.hdr.data_bo_start[3:0], lnk.hdr.data_bo_end[3:0]};
                    nxt_cur.left = lnk.hdr.num_elem;
                    nxt_cur.have_prev = 1'b0;
                    if (lnk.hdr.num_elem == 8'h00) begin
                        nxt_cur.done = 1'b1;
                    end else begin
                        nxt_cur.st = UMAPD_M_ELEM;
                    end
                end
            end
            UMAPD_M_ELEM: begin
                if (lnk.word_valid) begin
                    nxt_cur.left = cur_ff.left - 8'h01;
                    // previous interval closes at this offset
                    if (cur_ff.have_prev && !e_rsvd && e_iuc != `UMAPD_IUC_EXP && e_iuc != `UMAPD_IUC_DACK) begin
                        nxt_cur.iv_valid = (prof_of(cur_ff.p_iuc, cur_ff.p_sid) != UMAPD_PROF_NONE);
                        nxt_cur.iv_start = cur_ff.start + {18'h00000, cur_ff.p_ofs};
                        nxt_cur.iv_len = e_ofs - cur_ff.p_ofs;
                        nxt_cur.iv_sid = cur_ff.p_sid;
                        nxt_cur.iv_mine = (cur_ff.p_sid == MY_SID) || (cur_ff.p_iuc == `UMAPD_IUC_REQ);
                        nxt_cur.iv_pend = (e_ofs == cur_ff.p_ofs) &&
                            (cur_ff.p_iuc == `UMAPD_IUC_SHORT || cur_ff.p_iuc == `UMAPD_IUC_LONG);
                        nxt_cur.iv_prof = prof_of(cur_ff.p_iuc, cur_ff.p_sid);
                    end
                    if (e_grant || e_iuc == `UMAPD_IUC_REQ) begin
                        nxt_cur.have_prev = 1'b1;
                        nxt_cur.p_sid = e_sid;
                        nxt_cur.p_iuc = e_iuc;
                        nxt_cur.p_ofs = e_ofs;
                    end else if (e_iuc == `UMAPD_IUC_NULL) begin
                        nxt_cur.have_prev = 1'b0;
                    end
                    if (e_iuc == `UMAPD_IUC_EXP && e_ofs != 14'h0000) begin
                        nxt_cur.skip = e_ofs;
                        nxt_cur.st = UMAPD_M_SKIP;
                    end else if (cur_ff.left == 8'h01) begin
                        nxt_cur.done = 1'b1;
                        nxt_cur.st = UMAPD_M_IDLE;
                    end
                end
            end
            UMAPD_M_SKIP: begin
                if (lnk.word_valid) begin
                    nxt_cur.skip = cur_ff.skip - 14'h0001;
                    if (cur_ff.skip == 14'h0001) begin
                        if (cur_ff.left == 8'h00) begin
                            nxt_cur.done = 1'b1;
                            nxt_cur.st = UMAPD_M_IDLE;
                        end else begin
                            nxt_cur.st = UMAPD_M_ELEM;
                        end
                    end
                end
            end
            default: nxt_cur.st = UMAPD_M_IDLE;
        endcase
    end
    // =================================================================
    // state register
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cur_ff <= '{st: UMAPD_M_IDLE, iv_prof: UMAPD_PROF_NONE, left: 8'h00, skip: 14'h0000,
                p_sid: 14'h0000, p_iuc: 4'h0, p_ofs: 14'h0000, ucd: 8'h00, start: 32'h0, ack: 32'h0,
                bo: 16'h0000, iv_start: 32'h0, iv_len: 14'h0000, iv_sid: 14'h0000, default: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end
    // =================================================================
    // outputs straight from the state register; word ready tied high
    assign lnk.word_ready = 1'b1;
    assign UCD_COUNT = cur_ff.ucd;
    assign MAP_START = cur_ff.start;
    assign ACK_TIME = cur_ff.ack;
    assign RNG_BO_START = cur_ff.bo[15:12];
    assign RNG_BO_END = cur_ff.bo[11:8];
    assign DATA_BO_START = cur_ff.bo[7:4];
    assign DATA_BO_END = cur_ff.bo[3:0];
    assign COLLIDED = cur_ff.coll;
    assign IVAL_VALID = cur_ff.iv_valid;
    assign IVAL_START = cur_ff.iv_start;
    assign IVAL_LEN = cur_ff.iv_len;
    assign IVAL_SID = cur_ff.iv_sid;
    assign IVAL_MINE = cur_ff.iv_mine;
    assign IVAL_PENDING = cur_ff.iv_pend;
    assign IVAL_PROF = cur_ff.iv_prof;
    assign MAP_DONE = cur_ff.done;
endmodule

// ### umapd_properties.sv
`timescale 1ns/1ps
// =====================================================================
// link checker: watches the signals between the two ends
module umapd_properties
    import umapd_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic hdr_valid,
    input wire umapd_hdr_s hdr,
    input wire logic word_valid,
    input wire umapd_word_t word,
    input wire logic word_ready
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic [7:0] elem_left_ff;
    logic [13:0] ext_left_ff;
    // =================================================================
    // elements and expansion words still owed by the current map
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            elem_left_ff <= 8'h00;
            ext_left_ff <= 14'h0000;
        end else if (hdr_valid) begin
            elem_left_ff <= hdr.num_elem;
        end else if (word_valid) begin
            if (ext_left_ff != 14'h0000) begin
                ext_left_ff <= ext_left_ff - 14'h0001;
            end else begin
                elem_left_ff <= elem_left_ff - 8'h01;
                if (word[17:14] == 4'hF) begin
                    ext_left_ff <= word[13:0];
                end
            end
        end
    end
    // =================================================================
    // header fields and framing
    rng_start_zero_a: assert property (hdr_valid |-> hdr.rng_bo_start[7:4] == 4'h0)
        else $error("ranging backoff start upper bits set");
    rng_end_zero_a: assert property (hdr_valid |-> hdr.rng_bo_end[7:4] == 4'h0)
        else $error("ranging backoff end upper bits set");
    data_start_zero_a: assert property (hdr_valid |-> hdr.data_bo_start[7:4] == 4'h0)
        else $error("data backoff start upper bits set");
    data_end_zero_a: assert property (hdr_valid |-> hdr.data_bo_end[7:4] == 4'h0)
        else $error("data backoff end upper bits set");
    hdr_one_cycle_a: assert property (hdr_valid |=> !hdr_valid)
        else $error("header strobe longer than one cycle");
    word_owed_a: assert property (word_valid |-> !hdr_valid && (elem_left_ff != 8'h00 || ext_left_ff != 14'h0000))
        else $error("element word beyond the element count");
    map_whole_a: assert property (hdr_valid |-> elem_left_ff == 8'h00 && ext_left_ff == 14'h0000)
        else $error("header before previous map completed");
    ready_high_a: assert property (word_ready == 1'b1)
        else $error("word ready dropped");
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
    import umapd_pkg::*;
    logic CLK, SYS_RST, START, ELEM_VALID, ELEM_READY, BUSY, COLLIDED, IVAL_VALID, IVAL_MINE, IVAL_PENDING, MAP_DONE;
    umapd_hdr_s HDR_IN, wire_hdr;
    umapd_word_t ELEM_IN;
    logic [7:0] MY_CHAN, UCD_COUNT;
    logic [13:0] MY_SID, IVAL_LEN, IVAL_SID;
    logic [31:0] LAST_TX_TIME, MAP_START, ACK_TIME, IVAL_START;
    logic [3:0] RNG_BO_START, RNG_BO_END, DATA_BO_START, DATA_BO_END;
    umapd_prof_e IVAL_PROF;
    int n_mismatch, cmp_count, done_cnt;
    logic [31:0] q_start[$];
    logic [13:0] q_len[$];
    logic [13:0] q_sid[$];
    logic q_mine[$], q_pend[$];
    umapd_prof_e q_prof[$];
    umapd_if lnk_if ();
    umapd_headend u_umapd_headend (.CLK(CLK), .SYS_RST(SYS_RST), .START(START), .HDR_IN(HDR_IN),
        .ELEM_VALID(ELEM_VALID), .ELEM_IN(ELEM_IN), .ELEM_READY(ELEM_READY), .BUSY(BUSY), .lnk(lnk_if));
    umapd_modem #(.M_BITS(4)) u_umapd_modem (.CLK(CLK), .SYS_RST(SYS_RST), .MY_CHAN(MY_CHAN), .MY_SID(MY_SID),
        .LAST_TX_TIME(LAST_TX_TIME), .lnk(lnk_if), .UCD_COUNT(UCD_COUNT), .MAP_START(MAP_START),
        .ACK_TIME(ACK_TIME), .RNG_BO_START(RNG_BO_START), .RNG_BO_END(RNG_BO_END), .DATA_BO_START(DATA_BO_START),
        .DATA_BO_END(DATA_BO_END), .COLLIDED(COLLIDED), .IVAL_VALID(IVAL_VALID), .IVAL_START(IVAL_START),
        .IVAL_LEN(IVAL_LEN), .IVAL_SID(IVAL_SID), .IVAL_MINE(IVAL_MINE), .IVAL_PENDING(IVAL_PENDING),
        .IVAL_PROF(IVAL_PROF), .MAP_DONE(MAP_DONE));
    umapd_properties u_umapd_properties (.CLK(CLK), .SYS_RST(SYS_RST), .hdr_valid(lnk_if.hdr_valid),
        .hdr(lnk_if.hdr), .word_valid(lnk_if.word_valid), .word(lnk_if.word), .word_ready(lnk_if.word_ready));
    // =================================================================
    // clock and output capture on the quiet edge
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(negedge CLK) begin
        if (MAP_DONE === 1'b1) done_cnt++;
        if (lnk_if.hdr_valid === 1'b1) wire_hdr = lnk_if.hdr;
        if (IVAL_VALID === 1'b1) begin
            q_start.push_back(IVAL_START);
            q_len.push_back(IVAL_LEN);
            q_sid.push_back(IVAL_SID);
            q_mine.push_back(IVAL_MINE);
            q_pend.push_back(IVAL_PENDING);
            q_prof.push_back(IVAL_PROF);
        end
    end
    // =================================================================
    // compare, closing report and map sender
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // a used-up wait bound counts as a mismatch and ends the run
    task automatic tmo(input int n);
        if (n >= 100) begin
            chk(32'h0, 32'h1, "wait limit");
            end_sim();
        end
    endtask
    // empty the captured interval queues before a new map
    task automatic clr_q();
        q_start = {};
        q_len = {};
        q_sid = {};
        q_mine = {};
        q_pend = {};
        q_prof = {};
    endtask
    // n_elem counts elements only, not the extra words of an expansion element
    task automatic send_map(input logic [7:0] chan, input logic [7:0] n_elem, input umapd_word_t w[$],
        input bit want_done);
        int n, d0;
        n = 0;
        d0 = done_cnt;
        while (BUSY !== 1'b0 && n < 100) begin
            @(posedge CLK);
            #1 n++;
        end
        tmo(n);
        HDR_IN = '{chan, 8'h2A, n_elem, 32'hFFC0_0100, 32'h1234_5678, 8'hF3, 8'hF7, 8'hF2, 8'hF9};
        START = 1'b1;
        @(posedge CLK);
        #1 START = 1'b0;
        HDR_IN.num_elem = 8'h00;
        foreach (w[i]) begin
            ELEM_VALID = 1'b1;
            ELEM_IN = w[i];
            #1 n = 0;
            while (ELEM_READY !== 1'b1 && n < 100) begin
                @(posedge CLK);
                #1 n++;
            end
            tmo(n);
            @(posedge CLK);
            #1;
        end
        // valid stays up between words and drops once after the last one
        ELEM_VALID = 1'b0;
        n = 0;
        while (want_done && done_cnt == d0 && n < 100) begin
            @(posedge CLK);
            #1 n++;
        end
        tmo(n);
    endtask
    // =================================================================
    // every usage code that opens an interval, lengths, header fields
    task automatic scen_codes();
        umapd_word_t w[$];
        int e_ofs[6] = '{0, 4, 10, 20, 30, 30};
        int e_len[6] = '{4, 6, 10, 10, 0, 20};
        w = '{{14'h0123, 4'h1, 14'h0000}, {14'h3E05, 4'h2, 14'h0004}, {14'h3FFF, 4'h3, 14'h000A},
              {MY_SID, 4'h4, 14'h0014}, {MY_SID, 4'h5, 14'h001E}, {14'h0055, 4'h6, 14'h001E},
              {14'h0000, 4'h7, 14'h0032}};
        send_map(MY_CHAN, 8'h07, w, 1'b1);
        chk(q_start.size(), 6, "interval count");
        for (int i = 0; i < 6 && i < q_start.size(); i++) begin
            chk(q_start[i], 32'h100 + e_ofs[i], "interval start");
            chk(q_len[i], e_len[i], "interval length");
            chk(q_prof[i], i + 1, "burst profile");
            chk(q_pend[i], i == 4, "grant pending");
        end
        if (q_start.size() == 6) chk({q_mine[0], q_mine[3], q_mine[4], q_mine[5]}, 4'hE, "own interval");
        chk(MAP_START, 32'h0000_0100, "map start");
        chk(ACK_TIME, 32'h0034_5678, "ack time");
        chk(UCD_COUNT, 8'h2A, "ucd count");
        chk({RNG_BO_START, RNG_BO_END}, 8'h37, "ranging backoff");
        chk({DATA_BO_START, DATA_BO_END}, 8'h29, "data backoff");
        chk(wire_hdr.rng_bo_start, 8'h03, "link backoff field");
        chk(COLLIDED, 1'b1, "tx already processed");
        chk(BUSY, 1'b0, "headend idle after map");
    endtask
    // =================================================================
    // reserved, expansion and data-ack elements open no interval
    task automatic scen_skip();
        umapd_word_t w[$];
        clr_q();
        LAST_TX_TIME = 32'h0034_9000;
        w = '{{14'h0077, 4'h9, 14'h0000}, {14'h0077, 4'hF, 14'h0002}, {MY_SID, 4'h5, 14'h0001},
              {MY_SID, 4'h6, 14'h0003}, {MY_SID, 4'h8, 14'h000C}, {MY_SID, 4'h5, 14'h0008},
              {14'h0000, 4'h7, 14'h000C}};
        send_map(MY_CHAN, 8'h05, w, 1'b1);
        chk(q_start.size(), 1, "single grant");
        if (q_start.size() == 1) chk(q_start[0], 32'h0000_0108, "grant start");
        if (q_start.size() == 1) chk(q_len[0], 32'h0000_0004, "grant length");
        if (q_start.size() == 1) chk(q_sid[0], MY_SID, "grant sid");
        chk(COLLIDED, 1'b0, "tx after ack time");
    endtask
    // =================================================================
    // a map for another channel is ignored
    task automatic scen_chan();
        umapd_word_t w[$];
        clr_q();
        LAST_TX_TIME = 32'h0000_0000;
        w = '{{MY_SID, 4'h5, 14'h0000}, {14'h0000, 4'h7, 14'h0005}};
        send_map(MY_CHAN ^ 8'h01, 8'h02, w, 1'b0);
        repeat (20) @(posedge CLK);
        chk(q_start.size(), 0, "foreign map intervals");
        chk(MAP_START, 32'h0000_0100, "map start kept");
        chk(COLLIDED, 1'b0, "collision flag kept");
    endtask
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        done_cnt = 0;
        SYS_RST = 1'b1;
        START = 1'b0;
        ELEM_VALID = 1'b0;
        ELEM_IN = 32'h0000_0000;
        HDR_IN = '0;
        MY_CHAN = 8'h05;
        MY_SID = 14'h0155;
        LAST_TX_TIME = 32'h0034_5000;
        repeat (12) @(posedge CLK);
        #1 SYS_RST = 1'b0;
        scen_codes();
        scen_skip();
        scen_chan();
        end_sim();
    end
endmodule
